// ---- rtl/tw_client.sv ----
`timescale 1ns/1ps
// Operation
// [R1] Wire interface disabled until firmware enables it
// [R2] Any negotiated rate between limits is supported
// [R3] Every answer carries a CRC for host
// [R4] Target stored unsigned; host treats as negative
// [R5] Report is offset below trip; zero activates
// [R6] Sample interval programmable, default shortest, capped
// [R7] Filtered equals half previous plus half new
// [R8] Fixed filter, on after reset, can disable
// [R9] Socket zero and one answer fixed addresses
// [R10] Two thermal domains selected per request
// [R11] Client always answers valid enabled requests
// [R12] Data invalid until first sample after reset
// [R13] Host protects after three failed reads
// [R14] Host may alert software on faults
// [R15] Errors return general or underflow codes
// [R16] Filter seeded with first raw sample
module tw_client #(
	parameter int SAMPLE_MAX_CYC = tw_pkg::TW_SAMPLE_MAX_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	// Sensor side, one sample per domain
	input wire tw_pkg::tw_sample_t [1:0] dts_sample,
	output logic dts_sample_req,
	// Wire protocol side
	input wire logic socket_sel,
	input wire tw_pkg::tw_req_t req,
	output tw_pkg::tw_rsp_t rsp,
	output logic [1:0] tcc_active
);

	// ==========================================
	// Declarations
	logic en_q; // Wire interface enable
	logic filt_q; // Averaging filter enable
	logic [tw_pkg::TW_IVL_W-1:0] ivl_q; // Sample interval in cycles
	logic [tw_pkg::TW_IVL_W-1:0] cnt_q; // Sample timer
	logic [15:0] target_q; // Fan control threshold magnitude
	logic [tw_pkg::TW_ST_W-1:0] st_q; // Sticky status
	logic [tw_pkg::TW_ST_W-1:0] mask_q; // Interrupt mask
	logic [tw_pkg::TW_ST_W-1:0] ev; // Events this cycle
	logic [15:0] mag_q [2]; // Filtered magnitude per domain
	logic [15:0] code [2]; // Reported word per domain
	logic [1:0] seeded_q; // Filter holds a real sample
	logic [1:0] fault_q; // Last sample was faulty
	logic [1:0] under_q; // Last sample was below range and not faulty
	logic [1:0] tcc_rise; // Activation edges
	logic hit; // Request is ours
	logic [tw_pkg::TW_IVL_W-1:0] ivl_wr; // Clamped interval write
	logic [tw_pkg::TW_IVL_W-1:0] ivl_min; // Shortest interval
	logic [tw_pkg::TW_IVL_W-1:0] ivl_max; // Longest interval

	assign ivl_min = tw_pkg::TW_IVL_W'(tw_pkg::TW_SAMPLE_MIN_CYC);
	assign ivl_max = tw_pkg::TW_IVL_W'(SAMPLE_MAX_CYC);

	// CRC over the answer word, most significant bit first
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 15; i >= 0; i--) begin
			if (c[7] ^ d[i]) begin
				c = {c[6:0], 1'b0} ^ tw_pkg::TW_CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction

	// ==========================================
	// Control register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			en_q <= tw_pkg::TW_RST_EN; // [R1]
			filt_q <= tw_pkg::TW_RST_FILT; // [R8]
		end else if (reg_wr && reg_addr == tw_pkg::TW_OFS_CTRL) begin
			en_q <= reg_wdata[tw_pkg::TW_CTRL_EN_BIT];
			filt_q <= reg_wdata[tw_pkg::TW_CTRL_FILT_BIT];
		end
	end

	// ==========================================
	// Sample interval, clamped to its legal range
	always_comb begin
		if (reg_wdata[tw_pkg::TW_IVL_W-1:0] < ivl_min) begin
			ivl_wr = ivl_min;
		end else if (reg_wdata[tw_pkg::TW_IVL_W-1:0] > ivl_max) begin
			ivl_wr = ivl_max; // [R6]
		end else begin
			ivl_wr = reg_wdata[tw_pkg::TW_IVL_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ivl_q <= tw_pkg::TW_IVL_W'(tw_pkg::TW_SAMPLE_MIN_CYC); // [R6]
		end else if (reg_wr && reg_addr == tw_pkg::TW_OFS_INTERVAL) begin
			ivl_q <= ivl_wr; // [R6]
		end
	end

	// ==========================================
	// Sample timer, one request pulse per interval
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt_q <= '0;
			dts_sample_req <= 1'b0;
		end else if (cnt_q + 1'b1 >= ivl_q) begin
			cnt_q <= '0;
			dts_sample_req <= 1'b1; // [R6]
		end else begin
			cnt_q <= cnt_q + 1'b1;
			dts_sample_req <= 1'b0;
		end
	end

	// ==========================================
	// Thermal target register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			target_q <= tw_pkg::TW_RST_TARGET;
		end else if (reg_wr && reg_addr == tw_pkg::TW_OFS_TARGET) begin
			target_q <= reg_wdata[15:0]; // [R4]
		end
	end

	// ==========================================
	// Per domain sensor state and filter
	generate
		for (genvar g = 0; g < 2; g++) begin : g_dom
			logic [16:0] sum; // Sum before halving
			assign sum = {1'b0, mag_q[g]} + {1'b0, dts_sample[g].mag};

			// Filter and seeding
			always_ff @(posedge clk) begin
				if (!rstn) begin
					mag_q[g] <= 16'h0000;
					seeded_q[g] <= 1'b0; // [R12]
				end else if (dts_sample[g].valid && !dts_sample[g].fault
						&& !dts_sample[g].under) begin
					seeded_q[g] <= 1'b1;
					if (filt_q && seeded_q[g]) begin
						mag_q[g] <= sum[16:1]; // [R7]
					end else begin
						mag_q[g] <= dts_sample[g].mag; // [R8] [R16]
					end
				end else if (!filt_q) begin
					// While the filter is off, a rejected valid sample drops the seed
					seeded_q[g] <= seeded_q[g] & ~(dts_sample[g].valid); // [R16]
				end
			end

			// Error state of last sample
			always_ff @(posedge clk) begin
				if (!rstn) begin
					fault_q[g] <= 1'b0;
					under_q[g] <= 1'b0;
				end else if (dts_sample[g].valid) begin
					fault_q[g] <= dts_sample[g].fault;
					under_q[g] <= dts_sample[g].under & ~dts_sample[g].fault;
				end
			end

			// Activation when count reaches zero
			always_ff @(posedge clk) begin
				if (!rstn) begin
					tcc_active[g] <= 1'b0;
				end else begin
					tcc_active[g] <= seeded_q[g] && mag_q[g] == 16'h0000; // [R5]
				end
			end
			assign tcc_rise[g] = seeded_q[g] && mag_q[g] == 16'h0000 && !tcc_active[g];

			// Reported word: negative offset or error code
			always_comb begin
				if (fault_q[g] || !seeded_q[g]) begin
					code[g] = tw_pkg::TW_ERR_GENERAL; // [R15] [R12]
				end else if (under_q[g]) begin
					code[g] = tw_pkg::TW_ERR_UNDER; // [R15]
				end else begin
					code[g] = 16'h0000 - mag_q[g]; // [R5]
				end
			end
		end
	endgenerate

	// ==========================================
	// Request decode and answer
	assign hit = req.valid && en_q && req.addr == (socket_sel ? tw_pkg::TW_ADDR_SOCK1
			: tw_pkg::TW_ADDR_SOCK0); // [R1] [R9]

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rsp <= '0;
		end else if (hit) begin
			rsp.valid <= 1'b1; // [R11]
			rsp.data <= code[req.domain]; // [R10]
			rsp.crc <= crc8(code[req.domain]); // [R3]
		end else begin
			rsp.valid <= 1'b0;
		end
	end

	// ==========================================
	// Interrupt status, set wins over clear
	always_comb begin
		ev = '0;
		ev[tw_pkg::TW_ST_TCC] = |tcc_rise;
		ev[tw_pkg::TW_ST_FAULT] = |(fault_q & ~seeded_q) | (dts_sample[0].valid
				& dts_sample[0].fault) | (dts_sample[1].valid & dts_sample[1].fault);
		ev[tw_pkg::TW_ST_UNDER] = (dts_sample[0].valid & dts_sample[0].under)
				| (dts_sample[1].valid & dts_sample[1].under);
		ev[tw_pkg::TW_ST_ANSWER] = hit;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_q <= '0;
		end else if (reg_wr && reg_addr == tw_pkg::TW_OFS_STATUS) begin
			st_q <= (st_q & ~reg_wdata[tw_pkg::TW_ST_W-1:0]) | ev;
		end else begin
			st_q <= st_q | ev;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			mask_q <= '0;
		end else if (reg_wr && reg_addr == tw_pkg::TW_OFS_MASK) begin
			mask_q <= reg_wdata[tw_pkg::TW_ST_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(st_q & mask_q);
		end
	end

	// ==========================================
	// Register read, data one cycle after strobe
	always_ff @(posedge clk) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				tw_pkg::TW_OFS_CTRL: reg_rdata <= {30'h0, filt_q, en_q};
				tw_pkg::TW_OFS_INTERVAL: reg_rdata <= {12'h0, ivl_q};
				tw_pkg::TW_OFS_TARGET: reg_rdata <= {16'h0, target_q}; // [R4]
				tw_pkg::TW_OFS_STATUS: reg_rdata <= {28'h0, st_q};
				tw_pkg::TW_OFS_MASK: reg_rdata <= {28'h0, mask_q};
				tw_pkg::TW_OFS_TEMP0: reg_rdata <= {16'h0, code[0]};
				tw_pkg::TW_OFS_TEMP1: reg_rdata <= {16'h0, code[1]};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

endmodule

// ---- inc/tw_pkg.sv ----
package tw_pkg;
	// ==========================================
	// Register map (byte addresses, one word each)
	localparam logic [7:0] TW_OFS_CTRL = 8'h00;
	localparam logic [7:0] TW_OFS_INTERVAL = 8'h04;
	localparam logic [7:0] TW_OFS_TARGET = 8'h08;
	localparam logic [7:0] TW_OFS_STATUS = 8'h0c;
	localparam logic [7:0] TW_OFS_MASK = 8'h10;
	localparam logic [7:0] TW_OFS_TEMP0 = 8'h14;
	localparam logic [7:0] TW_OFS_TEMP1 = 8'h18;

	// ==========================================
	// Control fields and reset values
	localparam int TW_CTRL_EN_BIT = 0;
	localparam int TW_CTRL_FILT_BIT = 1;
	localparam logic TW_RST_EN = 1'b0;
	localparam logic TW_RST_FILT = 1'b1;
	localparam logic [15:0] TW_RST_TARGET = 16'h0000;

	// ==========================================
	// Status bits, shared by status and mask
	localparam int TW_ST_TCC = 0;
	localparam int TW_ST_FAULT = 1;
	localparam int TW_ST_UNDER = 2;
	localparam int TW_ST_ANSWER = 3;
	localparam int TW_ST_W = 4;

	// ==========================================
	// Wire interface identity and codes
	localparam logic [7:0] TW_ADDR_SOCK0 = 8'h30;
	localparam logic [7:0] TW_ADDR_SOCK1 = 8'h31;
	localparam logic [15:0] TW_ERR_GENERAL = 16'h8000;
	localparam logic [15:0] TW_ERR_UNDER = 16'h8002;
	localparam logic [7:0] TW_CRC_POLY = 8'h07;
	localparam int TW_RATE_MIN_BPS = 2000;
	localparam int TW_RATE_MAX_BPS = 2000000;

	// ==========================================
	// Timing
	localparam int TW_CLK_HZ = 25000000;
	localparam int TW_SAMPLE_MIN_US = 82;
	localparam int TW_SAMPLE_MAX_MS = 20;
	localparam int TW_SAMPLE_MIN_CYC = (TW_SAMPLE_MIN_US * (TW_CLK_HZ / 1000) + 999) / 1000;
	localparam int TW_SAMPLE_MAX_CYC = TW_SAMPLE_MAX_MS * (TW_CLK_HZ / 1000);
	localparam int TW_IVL_W = 20;

	// ==========================================
	// Carriers
	typedef struct packed {
		logic valid;
		logic fault;
		logic under;
		logic [15:0] mag;
	} tw_sample_t;

	typedef struct packed {
		logic valid;
		logic [7:0] addr;
		logic domain;
	} tw_req_t;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
		logic [7:0] crc;
	} tw_rsp_t;
endpackage

// ---- testbench/tw_client_asserts.sv ----
`timescale 1ns/1ps
module tw_client_asserts #(
	parameter int SAMPLE_MAX_CYC = 500000
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic irq,
	input wire tw_pkg::tw_sample_t [1:0] dts_sample,
	input wire logic dts_sample_req,
	input wire logic socket_sel,
	input wire tw_pkg::tw_req_t req,
	input wire tw_pkg::tw_rsp_t rsp,
	input wire logic [1:0] tcc_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// ==========
	// Enable bit as software last wrote it
	logic en_q;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			en_q <= 1'h0;
		end else if (reg_wr && reg_addr == tw_pkg::TW_OFS_CTRL) begin
			en_q <= reg_wdata[tw_pkg::TW_CTRL_EN_BIT];
		end
	end
	// Request aimed at this client while enabled
	logic hit;
	assign hit = req.valid && en_q
		&& req.addr == (socket_sel ? tw_pkg::TW_ADDR_SOCK1 : tw_pkg::TW_ADDR_SOCK0);
	sequence s_hit; hit; endsequence
	sequence s_ans; ##1 rsp.valid; endsequence
	property p_ans; s_hit |-> s_ans; endproperty
	a_ans: assert property (p_ans) else $error("request not answered");
	property p_ref; !hit |=> !rsp.valid; endproperty
	a_ref: assert property (p_ref) else $error("answer without request");
	property p_rst; $rose(rstn) |-> rsp == '0 && !irq && tcc_active == 2'h0; endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared");
	property p_rd; !reg_rd |=> reg_rdata == 32'h0; endproperty
	a_rd: assert property (p_rd) else $error("read data outside slot");
	property p_hold; !rsp.valid |-> $stable({rsp.data, rsp.crc}); endproperty
	a_hold: assert property (p_hold) else $error("answer word moved");
	property p_req; dts_sample_req |=> !dts_sample_req [*8]; endproperty
	a_req: assert property (p_req) else $error("sample pulses too close");
	property p_tcc; $rose(tcc_active[1]) |-> $past(dts_sample[1].valid, 2); endproperty
	a_tcc: assert property (p_tcc) else $error("activation without sample");
	property p_ctrl;
		reg_rd && reg_addr == tw_pkg::TW_OFS_CTRL |=> reg_rdata[0] == en_q;
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("enable readback wrong");
endmodule
bind tw_client tw_client_asserts #(.SAMPLE_MAX_CYC(SAMPLE_MAX_CYC)) tw_client_asserts_inst (.clk,
	.rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .dts_sample,
	.dts_sample_req, .socket_sel, .req, .rsp, .tcc_active);

// ---- testbench/tw_host_model.sv ----
`timescale 1ns/1ps
module tw_host_model (
	input wire logic clk,
	input wire logic go,
	input wire logic [7:0] addr,
	input wire logic dom,
	input wire tw_pkg::tw_rsp_t rsp,
	output tw_pkg::tw_req_t req,
	output logic crc_ok,
	output logic alarm
);
	// Idle request lines show the inverted address and domain, not the last value
	assign req = go ? {1'h1, addr, dom} : {1'h0, ~addr, ~dom};
	// CRC-8 over the answer word, MSB first
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 15; i >= 0; i--) begin
			c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? tw_pkg::TW_CRC_POLY : 8'h00);
		end
		return c;
	endfunction
	assign crc_ok = crc8(rsp.data) === rsp.crc;
	// Successive answers carrying an error code
	logic [1:0] miss_q = 2'h0;
	always_ff @(posedge clk) begin
		if (rsp.valid) begin
			miss_q <= (rsp.data[15:2] != 14'h2000) ? 2'h0 : miss_q + {1'h0, miss_q != 2'h3};
		end
	end
	assign alarm = miss_q == 2'h3;
endmodule

// ---- testbench/tw_client_tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin bad_count++; \
	$display("[FAIL] %s exp %h got %h", n, e, s); end end
module tw_client_tb;
	localparam int MAXC = 3000;
	localparam logic [7:0] S0 = tw_pkg::TW_ADDR_SOCK0;
	localparam logic [7:0] S1 = tw_pkg::TW_ADDR_SOCK1;
	// Rows: domain, fault, under, magnitude, expected answer
	localparam logic [34:0] ROWS [6] = '{
		{3'h0, 16'h0064, 16'hff9c},
		{3'h0, 16'h0032, 16'hffb5},
		{3'h4, 16'h0000, 16'h0000},
		{3'h5, 16'h0010, 16'h8002},
		{3'h6, 16'h0010, 16'h8000},
		{3'h0, 16'h0000, 16'hffdb}};
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [31:0] reg_rdata;
	logic irq;
	tw_pkg::tw_sample_t [1:0] smp = '0;
	logic sreq;
	logic sock = 1'h0;
	logic go = 1'h0;
	logic [7:0] haddr = 8'h00;
	logic hdom = 1'h0;
	tw_pkg::tw_req_t req;
	tw_pkg::tw_rsp_t rsp;
	logic [1:0] thermal_control_circuit;
	logic crc_ok;
	int bad_count = 0;
	int check_count = 0;
	int n;
	always #20 clk = ~clk;
	tw_client #(.SAMPLE_MAX_CYC(MAXC)) tw_client_inst (.clk(clk), .rstn(rstn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq), .dts_sample(smp), .dts_sample_req(sreq),
		.socket_sel(sock), .req(req), .rsp(rsp), .tcc_active(thermal_control_circuit));
	tw_host_model tw_host_model_inst (.clk(clk), .go(go), .addr(haddr), .dom(hdom),
		.rsp(rsp), .req(req), .crc_ok(crc_ok), .alarm());
	// ==========
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 `CHK("rdata", e, reg_rdata)
	endtask
	task automatic ask(input logic [7:0] a, input logic d, input logic v, input logic [15:0] e);
		@(posedge clk);
		go <= 1'h1;
		haddr <= a;
		hdom <= d;
		@(posedge clk);
		go <= 1'h0;
		#1 `CHK("valid", v, rsp.valid)
		if (v) `CHK("data", e, rsp.data)
		if (v) `CHK("crc", 1'h1, crc_ok)
	endtask
	task automatic smpl(input logic [2:0] k, input logic [15:0] m);
		@(posedge clk);
		smp[k[2]] <= {1'h1, k[1:0], m};
		@(posedge clk);
		smp[k[2]].valid <= 1'h0;
	endtask
	task automatic report_and_stop;
		if (bad_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ==========
	// Main sequence: reset checks, table rows, then hand-written cases
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'h1;
		rdc(tw_pkg::TW_OFS_CTRL, 32'h2);
		rdc(tw_pkg::TW_OFS_INTERVAL, 32'(tw_pkg::TW_SAMPLE_MIN_CYC));
		rdc(8'h40, 32'h0);
		ask(S0, 1'h0, 1'h0, 16'h0);
		wr(tw_pkg::TW_OFS_CTRL, 32'h3);
		ask(S0, 1'h1, 1'h1, tw_pkg::TW_ERR_GENERAL);
		for (int i = 0; i < 6; i++) begin
			smpl({ROWS[i][34], ROWS[i][33:32]}, ROWS[i][31:16]);
			ask(S0, ROWS[i][34], 1'h1, ROWS[i][15:0]);
		end
		repeat (2) @(posedge clk);
		#1 `CHK("tcc", 2'h2, thermal_control_circuit)
		ask(S1, 1'h0, 1'h0, 16'h0);
		sock <= 1'h1;
		ask(S1, 1'h0, 1'h1, 16'hffdb);
		wr(tw_pkg::TW_OFS_TARGET, 32'h50);
		rdc(tw_pkg::TW_OFS_TARGET, 32'h50);
		wr(tw_pkg::TW_OFS_CTRL, 32'h1);
		smpl(3'h0, 16'h00c8);
		ask(S1, 1'h0, 1'h1, 16'hff38);
		wr(tw_pkg::TW_OFS_STATUS, 32'hf);
		wr(tw_pkg::TW_OFS_MASK, 32'h8);
		ask(S1, 1'h0, 1'h1, 16'hff38);
		@(posedge clk);
		#1 `CHK("irq", 1'h1, irq)
		rdc(tw_pkg::TW_OFS_STATUS, 32'h8);
		wr(tw_pkg::TW_OFS_STATUS, 32'h8);
		@(posedge clk);
		#1 `CHK("irq", 1'h0, irq)
		wr(tw_pkg::TW_OFS_INTERVAL, 32'h0);
		rdc(tw_pkg::TW_OFS_INTERVAL, 32'(tw_pkg::TW_SAMPLE_MIN_CYC));
		wr(tw_pkg::TW_OFS_INTERVAL, 32'hfffff);
		rdc(tw_pkg::TW_OFS_INTERVAL, 32'(MAXC));
		@(posedge clk iff sreq);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!sreq);
		`CHK("interval", MAXC, n)
		rstn <= 1'h0;
		repeat (2) @(posedge clk);
		rstn <= 1'h1;
		rdc(tw_pkg::TW_OFS_CTRL, 32'h2);
		ask(S1, 1'h0, 1'h0, 16'h0);
		report_and_stop();
	end
	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		report_and_stop();
	end
endmodule
